/* icd_decoder.sv */
// Instruction cycle decoder with an AHB-Lite register slave.
//
// Functional notes
// - Each instruction is one 14-bit word holding opcode and operands.
// - Opcodes sort into byte file, bit file and literal/control classes.
// - Without an exception every instruction completes in one instruction cycle.
// - Direct call and call through working register take two cycles.
// - Return, return with literal and return from interrupt take two cycles.
// - Jumps and branches take two cycles; bit-test and counting skips take two only when the test is true.
// - A program counter change or true test adds a no-operation second cycle.
// - Indirect access through a pointer into program memory adds one cycle.
// - An instruction cycle is four oscillator cycles.
// - File instructions read, modify and store per instruction or destination bit.
// - The named file register is read even when only written.
// - File address field is seven bits, locations 0x00 to 0x7F.
// - Bit number field is three bits, one of eight positions.
// - Destination bit 0 stores to working register, 1 to file register.
// - Don't-care bit positions never affect decoding.
// - Pointer number field selects pointer pair 0 or 1.
// - Two-bit pointer update mode selects pre/post increment or decrement.
// - Literal field is passed to datapath and program counter logic.
`timescale 1ns/1ps
`default_nettype none

module icd_decoder
(
   // Clock and reset.
   input  wire logic        CLK_SYS,
   input  wire logic        SRST,
   // AHB-Lite slave.
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // Datapath and register file control.
   output icd_pkg::icd_decode_t DEC_OUT,
   output logic             FILE_RD_STB,
   output logic             FILE_WR_STB,
   output logic             W_WR_STB,
   output logic             NOP_CYCLE,
   output logic             INSTR_DONE
);

   // Bus state.
   logic        dp_pend_reg;
   logic        dp_write_reg;
   logic [7:0]  dp_addr_reg;
   logic        hready_reg;
   logic [31:0] hrdata_reg;
   logic        hresp_reg;

   // Software visible state.
   logic [2:0]  ctrl_reg;
   logic [13:0] instr_reg;
   logic [7:0]  done_cnt_reg;

   // Execution state.
   icd_pkg::icd_state_t  state_reg;
   icd_pkg::icd_state_t  state_next;
   icd_pkg::icd_decode_t dec_reg;
   logic [1:0]  left_reg;
   logic [1:0]  left_next;
   logic        first_reg;
   logic        rd_stb_reg;
   logic        wr_stb_reg;
   logic        w_stb_reg;
   logic        nop_reg;
   logic        done_reg;

   logic [1:0]  phase;
   logic        q_end;

   // Address phase and data phase decode.
   wire         ap_take   = HSEL & HTRANS[1] & HREADY;
   wire         sel_ctrl  = (dp_addr_reg == icd_pkg::ICD_OFS_CTRL);
   wire         sel_instr = (dp_addr_reg == icd_pkg::ICD_OFS_INSTR);
   wire         busy      = (state_reg == icd_pkg::ICD_ST_EXEC);
   wire         blocked   = dp_write_reg & sel_instr & busy;
   wire         dp_act    = dp_pend_reg & ~blocked;
   wire         start     = dp_act & dp_write_reg & sel_instr;
   wire         ctrl_wr   = dp_act & dp_write_reg & sel_ctrl;

   // Instruction word fields.
   wire [13:0]  iw     = HWDATA[icd_pkg::ICD_IW_W-1:0];
   wire [1:0]   op_hi  = iw[13:12];
   wire [3:0]   op_mid = iw[11:8];
   wire [6:0]   fadr   = iw[6:0];
   wire [2:0]   bitn   = iw[9:7];

   // Class decode.
   wire is_bit    = (op_hi == 2'b01);
   wire is_byte11 = (op_hi == 2'b11) &
                    ((op_mid == 4'h5) | (op_mid == 4'h6) | (op_mid == 4'h7) |
                     (op_mid == 4'hb) | (op_mid == 4'hd));
   wire is_ctl0   = (op_hi == 2'b00) & (op_mid == 4'h0) & ~iw[7];
   wire is_byte   = ((op_hi == 2'b00) & ~is_ctl0) | is_byte11;
   wire is_clrw   = (op_hi == 2'b00) & (op_mid == 4'h1) & (iw[7:2] == 6'h00);
   wire uses_file = (is_byte & ~is_clrw) | is_bit;
   icd_pkg::icd_class_t cls;
   assign cls = is_bit  ? icd_pkg::ICD_CLS_BIT  :
                is_byte ? icd_pkg::ICD_CLS_BYTE :
                          icd_pkg::ICD_CLS_LIT;

   // Control transfers.
   wire is_call    = (op_hi == 2'b10) & ~iw[11];
   wire is_jump    = (op_hi == 2'b10) & iw[11];
   wire is_call_via_working_reg   = (iw == icd_pkg::ICD_OP_CALL_VIA_WORKING_REG);
   wire is_return  = (iw == icd_pkg::ICD_OP_RETURN);
   wire is_retfi   = (iw == icd_pkg::ICD_OP_RETFI);
   wire is_brw     = (iw == icd_pkg::ICD_OP_BRW);
   wire is_retlit  = (op_hi == 2'b11) & (op_mid == 4'h4);
   wire is_bra     = (op_hi == 2'b11) & (iw[11:9] == 3'b001);
   wire is_bitskip = is_bit & iw[11];
   wire is_cntskip = (op_hi == 2'b00) & ((op_mid == 4'hb) | (op_mid == 4'hf));
   wire pcl_write  = is_byte & uses_file & iw[7] & (fadr == icd_pkg::ICD_FADR_PCL);

   // Indirect moves and pointer selection.
   wire is_indmove = is_ctl0 & (iw[7:4] == 4'h1);
   wire is_indexed = (op_hi == 2'b11) & (op_mid == 4'hf);
   wire [1:0] mode = is_indmove ? iw[1:0] : 2'b00;
   wire ptr_num    = is_indmove ? iw[2] :
                     is_indexed ? iw[6] : fadr[0];
   wire indir_ref  = (uses_file & (fadr[6:1] == 6'h00)) | is_indmove | is_indexed;
   wire ptr_prog   = ptr_num ? ctrl_reg[icd_pkg::ICD_CTRL_PTR1_PROG]
                             : ctrl_reg[icd_pkg::ICD_CTRL_PTR0_PROG];

   // Cycle count.
   wire two_call   = is_call | is_call_via_working_reg;
   wire two_ret    = is_return | is_retlit | is_retfi;
   wire two_branch = is_jump | is_bra | is_brw | pcl_write;
   wire skip_true  = (is_bitskip | is_cntskip) & ctrl_reg[icd_pkg::ICD_CTRL_COND];
   wire add_two    = two_call | two_ret | two_branch | skip_true;
   wire add_ind    = indir_ref & ptr_prog;
   wire [1:0] cycles = 2'h1 + {1'b0, add_two} + {1'b0, add_ind};

   // Read-modify-write strobes and destination.
   wire dest     = is_byte ? iw[7] : is_bit;
   wire file_rd  = uses_file;
   wire file_wr  = uses_file & (is_byte ? iw[7] : ~iw[11]);
   wire w_wr     = (is_byte & uses_file & ~iw[7]) | is_clrw;

   icd_pkg::icd_decode_t dec_new;
   assign dec_new.cls     = cls;
   assign dec_new.fadr    = fadr;
   assign dec_new.bitn    = is_bit ? bitn : 3'h0;
   assign dec_new.dest    = dest;
   assign dec_new.ptr     = ptr_num;
   assign dec_new.mode    = mode;
   assign dec_new.lit     = iw[icd_pkg::ICD_LIT_W-1:0];
   assign dec_new.file_rd = file_rd;
   assign dec_new.file_wr = file_wr;
   assign dec_new.w_wr    = w_wr;
   assign dec_new.cycles  = cycles;

   // Execution sequencing.
   wire last_cyc = (left_reg == 2'h1);
   wire cyc_end  = busy & q_end;
   assign state_next = start ? icd_pkg::ICD_ST_EXEC :
                       (cyc_end & last_cyc) ? icd_pkg::ICD_ST_IDLE : state_reg;
   assign left_next  = start ? cycles : cyc_end ? left_reg - 2'h1 : left_reg;

   // Registered strobes are decided one phase early so each stands in its own phase.
   // Otherwise the store of the first cycle would spill into the following filler cycle.
   wire [1:0] phase_nx = phase + 2'h1;
   wire       lead_cyc = busy & first_reg;
   wire       rd_due   = lead_cyc & dec_reg.file_rd &
                         (phase_nx == icd_pkg::ICD_RD_PHASE);
   wire       wr_due   = lead_cyc & dec_reg.file_wr &
                         (phase_nx == icd_pkg::ICD_WR_PHASE);
   wire       w_due    = lead_cyc & dec_reg.w_wr &
                         (phase_nx == icd_pkg::ICD_WR_PHASE);
   wire       nop_due  = (state_next == icd_pkg::ICD_ST_EXEC) & ~start &
                         (cyc_end | ~first_reg);
   wire       done_due = cyc_end & last_cyc;

   // Read data selection.
   wire [31:0] status_word = {16'h0000, done_cnt_reg, 3'h0, phase, left_reg, busy};
   wire [31:0] rd_word =
      (dp_addr_reg == icd_pkg::ICD_OFS_CTRL)   ? {29'h0, ctrl_reg}  :
      (dp_addr_reg == icd_pkg::ICD_OFS_INSTR)  ? {18'h0, instr_reg} :
      (dp_addr_reg == icd_pkg::ICD_OFS_DECODE) ? dec_reg            :
      (dp_addr_reg == icd_pkg::ICD_OFS_STATUS) ? status_word        : 32'h0000_0000;

   icd_qphase u_qphase
   (
      .clk     (CLK_SYS),
      .srst    (SRST),
      .restart (start),
      .phase   (phase),
      .q_end   (q_end)
   );

   // Bus slave: one wait state, longer while an instruction write must wait.
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         dp_pend_reg  <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_addr_reg  <= 8'h00;
         hready_reg   <= 1'b1;
         hrdata_reg   <= 32'h0000_0000;
         hresp_reg    <= 1'b0;
      end
      else if (dp_pend_reg)
      begin
         if (dp_act)
         begin
            dp_pend_reg <= 1'b0;
            hready_reg  <= 1'b1;
            hrdata_reg  <= dp_write_reg ? 32'h0000_0000 : rd_word;
         end
      end
      else if (ap_take)
      begin
         dp_pend_reg  <= 1'b1;
         dp_write_reg <= HWRITE;
         dp_addr_reg  <= {HADDR[7:2], 2'b00};
         hready_reg   <= 1'b0;
      end
   end

   // Software registers.
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         ctrl_reg     <= icd_pkg::ICD_CTRL_RESET;
         instr_reg    <= 14'h0000;
         done_cnt_reg <= icd_pkg::ICD_CNT_RESET;
      end
      else
      begin
         if (ctrl_wr)
            ctrl_reg <= HWDATA[2:0];
         if (start)
            instr_reg <= iw;
         if (cyc_end & last_cyc)
            done_cnt_reg <= done_cnt_reg + 8'h01;
      end
   end

   // Instruction execution over whole instruction cycles.
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         state_reg <= icd_pkg::ICD_ST_IDLE;
         dec_reg   <= icd_pkg::ICD_DEC_RESET;
         left_reg  <= 2'h0;
         first_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         left_reg  <= left_next;
         if (start)
            dec_reg <= dec_new;
         if (start)
            first_reg <= 1'b1;
         else if (cyc_end)
            first_reg <= 1'b0;
      end
   end

   // Datapath strobes: read in the second phase, store in the last phase.
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         rd_stb_reg <= 1'b0;
         wr_stb_reg <= 1'b0;
         w_stb_reg  <= 1'b0;
         nop_reg    <= 1'b0;
         done_reg   <= 1'b0;
      end
      else
      begin
         rd_stb_reg <= rd_due;
         wr_stb_reg <= wr_due;
         w_stb_reg  <= w_due;
         nop_reg    <= nop_due;
         done_reg   <= done_due;
      end
   end

   assign HRDATA      = hrdata_reg;
   assign HREADYOUT   = hready_reg;
   assign HRESP       = hresp_reg;
   assign DEC_OUT     = dec_reg;
   assign FILE_RD_STB = rd_stb_reg;
   assign FILE_WR_STB = wr_stb_reg;
   assign W_WR_STB    = w_stb_reg;
   assign NOP_CYCLE   = nop_reg;
   assign INSTR_DONE  = done_reg;

endmodule
`default_nettype wire

/* icd_pkg.sv */
// Constants, field layouts and types shared by the instruction cycle decoder.
`default_nettype none

package icd_pkg;

   // Register byte offsets.
   localparam logic [7:0] ICD_OFS_CTRL   = 8'h00;
   localparam logic [7:0] ICD_OFS_INSTR  = 8'h04;
   localparam logic [7:0] ICD_OFS_DECODE = 8'h08;
   localparam logic [7:0] ICD_OFS_STATUS = 8'h0c;

   // Control register fields and reset value.
   localparam int         ICD_CTRL_PTR0_PROG = 0;
   localparam int         ICD_CTRL_PTR1_PROG = 1;
   localparam int         ICD_CTRL_COND      = 2;
   localparam logic [2:0] ICD_CTRL_RESET     = 3'h0;

   // Status register fields.
   localparam int ICD_STAT_BUSY     = 0;
   localparam int ICD_STAT_LEFT_LSB = 1;
   localparam int ICD_STAT_PH_LSB   = 3;
   localparam int ICD_STAT_CNT_LSB  = 8;

   // Instruction word and field widths.
   localparam int ICD_IW_W   = 14;
   localparam int ICD_FADR_W = 7;
   localparam int ICD_BIT_W  = 3;
   localparam int ICD_LIT_W  = 11;

   // Oscillator cycles in one instruction cycle.
   localparam int         ICD_OSC_PER_ICYC = 4;
   localparam logic [1:0] ICD_LAST_PHASE   = 2'(ICD_OSC_PER_ICYC - 1);
   localparam logic [1:0] ICD_RD_PHASE     = 2'h1;
   localparam logic [1:0] ICD_WR_PHASE     = 2'h3;

   // Fixed instruction words of the control group.
   localparam logic [13:0] ICD_OP_RETURN   = 14'h0008;
   localparam logic [13:0] ICD_OP_RETFI    = 14'h0009;
   localparam logic [13:0] ICD_OP_CALL_VIA_WORKING_REG    = 14'h000a;
   localparam logic [13:0] ICD_OP_BRW      = 14'h000b;
   localparam logic [6:0]  ICD_FADR_PCL    = 7'h02;
   localparam logic [7:0]  ICD_CNT_RESET   = 8'h00;

   typedef enum logic [1:0]
   {
      ICD_CLS_BYTE = 2'h0,
      ICD_CLS_BIT  = 2'h1,
      ICD_CLS_LIT  = 2'h2
   } icd_class_t;

   typedef enum logic [1:0]
   {
      ICD_ST_IDLE = 2'b01,
      ICD_ST_EXEC = 2'b10
   } icd_state_t;

   // Decoded instruction; 32 bits, also the image of the decode register.
   typedef struct packed
   {
      icd_class_t            cls;
      logic [ICD_FADR_W-1:0] fadr;
      logic [ICD_BIT_W-1:0]  bitn;
      logic                  dest;
      logic                  ptr;
      logic [1:0]            mode;
      logic [ICD_LIT_W-1:0]  lit;
      logic                  file_rd;
      logic                  file_wr;
      logic                  w_wr;
      logic [1:0]            cycles;
   } icd_decode_t;

   localparam icd_decode_t ICD_DEC_RESET = '0;

endpackage
`default_nettype wire

/* icd_qphase.sv */
// Divider that splits the system clock into the four phases of an instruction cycle.
`timescale 1ns/1ps
`default_nettype none

module icd_qphase
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       srst,
   // Restart the phase count at the start of an instruction.
   input  wire logic       restart,
   // Phase and end of instruction cycle.
   output logic [1:0] phase,
   output logic       q_end
);

   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;

   assign cnt_next = restart ? 2'h0 : cnt_reg + 2'h1;
   assign phase    = cnt_reg;
   assign q_end    = (cnt_reg == icd_pkg::ICD_LAST_PHASE);

   always_ff @(posedge clk)
   begin
      if (srst)
         cnt_reg <= 2'h0;
      else
         cnt_reg <= cnt_next;
   end

endmodule
`default_nettype wire

/* icd_decoder_assertions.sv */
// Concurrent checks on the ports of the instruction cycle decoder.
`timescale 1ns/1ps
`default_nettype none

module icd_decoder_assertions
(
   // Clock and reset.
   input wire logic                 CLK_SYS,
   input wire logic                 SRST,
   // AHB-Lite slave.
   input wire logic                 HSEL,
   input wire logic [31:0]          HADDR,
   input wire logic [1:0]           HTRANS,
   input wire logic                 HWRITE,
   input wire logic [2:0]           HSIZE,
   input wire logic [31:0]          HWDATA,
   input wire logic                 HREADY,
   input wire logic [31:0]          HRDATA,
   input wire logic                 HREADYOUT,
   input wire logic                 HRESP,
   // Datapath and register file control.
   input wire icd_pkg::icd_decode_t DEC_OUT,
   input wire logic                 FILE_RD_STB,
   input wire logic                 FILE_WR_STB,
   input wire logic                 W_WR_STB,
   input wire logic                 NOP_CYCLE,
   input wire logic                 INSTR_DONE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);

   a_read_first:
      assert property ((FILE_WR_STB || W_WR_STB) && DEC_OUT.file_rd |-> $past(FILE_RD_STB, 2))
      else $error("store without a prior file read");
   a_dest_file:
      assert property (FILE_WR_STB && DEC_OUT.cls == icd_pkg::ICD_CLS_BYTE |-> DEC_OUT.dest)
      else $error("file store with destination bit clear");
   a_dest_work:
      assert property (W_WR_STB && DEC_OUT.cls == icd_pkg::ICD_CLS_BYTE
                       |-> !DEC_OUT.dest && !FILE_WR_STB)
      else $error("working store with destination bit set");
   a_nop_quiet:
      assert property (NOP_CYCLE |-> !FILE_RD_STB && !FILE_WR_STB && !W_WR_STB)
      else $error("strobe during a filler cycle");
   a_one_cycle:
      assert property (FILE_RD_STB && DEC_OUT.cycles == 2'h1 |-> ##3 INSTR_DONE)
      else $error("single cycle instruction off its four clocks");
   a_two_cycle:
      assert property (FILE_RD_STB && DEC_OUT.cycles == 2'h2
                       |-> !INSTR_DONE [*7] ##1 INSTR_DONE)
      else $error("extended instruction off its eight clocks");
   a_nop_extra:
      assert property (INSTR_DONE && DEC_OUT.cycles == 2'h2 |-> $past(NOP_CYCLE))
      else $error("second cycle not a filler cycle");
   a_addr_wait:
      assert property (HSEL && HTRANS[1] && HREADY |=> !HREADYOUT)
      else $error("transfer taken without a wait state");
endmodule

`default_nettype wire

/* icd_datapath_model.sv */
// Datapath stand-in that counts the strobes the decoder issues.
`timescale 1ns/1ps
`default_nettype none

module icd_datapath_model
(
   // Clock and reset.
   input wire logic   clk,
   input wire logic   srst,
   // Strobes from the decoder.
   input wire logic   file_rd,
   input wire logic   file_wr,
   input wire logic   w_wr,
   input wire logic   done,
   // Counts seen since reset.
   output logic [7:0] rd_cnt,
   output logic [7:0] fw_cnt,
   output logic [7:0] ww_cnt,
   output logic [7:0] done_cnt
);
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rd_cnt   <= 8'h00;
         fw_cnt   <= 8'h00;
         ww_cnt   <= 8'h00;
         done_cnt <= 8'h00;
      end
      else
      begin
         rd_cnt   <= rd_cnt + 8'(file_rd);
         fw_cnt   <= fw_cnt + 8'(file_wr);
         ww_cnt   <= ww_cnt + 8'(w_wr);
         done_cnt <= done_cnt + 8'(done);
      end
   end
endmodule

`default_nettype wire

/* instruction_cycle_decoder_tb.sv */
// Testbench for the instruction cycle decoder.
`timescale 1ns/1ps
`default_nettype none

module instruction_cycle_decoder_tb;
   logic                 clk, srst, hsel, hwr, rdy, resp, rd_s, fw_s, ww_s, no_operation, done;
   logic [1:0]           htrans;
   logic [31:0]          haddr, hwdata, hrdata, q;
   logic [7:0]           n_rd, n_fw, n_ww, n_dn, b_dn;
   icd_pkg::icd_decode_t dec;
   int                   err_count, checked, cyc_n;
   // Word, control, cycles, class, expected read/file/working strobes (7 skips them).
   localparam logic [23:0] TBL [24] = '{
      {14'h07a0, 3'h0, 2'h1, 2'h0, 3'h6}, {14'h077f, 3'h0, 2'h1, 2'h0, 3'h5},
      {14'h1790, 3'h0, 2'h1, 2'h1, 3'h6}, {14'h1820, 3'h0, 2'h1, 2'h1, 3'h4},
      {14'h1c20, 3'h4, 2'h2, 2'h1, 3'h4}, {14'h0ba0, 3'h4, 2'h2, 2'h0, 3'h6},
      {14'h0f20, 3'h4, 2'h2, 2'h0, 3'h5}, {14'h2123, 3'h0, 2'h2, 2'h2, 3'h7},
      {14'h2d55, 3'h0, 2'h2, 2'h2, 3'h7}, {14'h0008, 3'h0, 2'h2, 2'h2, 3'h7},
      {14'h0009, 3'h0, 2'h2, 2'h2, 3'h7}, {14'h000a, 3'h0, 2'h2, 2'h2, 3'h7},
      {14'h000b, 3'h0, 2'h2, 2'h2, 3'h7}, {14'h3412, 3'h0, 2'h2, 2'h2, 3'h7},
      {14'h3205, 3'h0, 2'h2, 2'h2, 3'h7}, {14'h3055, 3'h0, 2'h1, 2'h2, 3'h7},
      {14'h0780, 3'h1, 2'h2, 2'h0, 3'h6}, {14'h0781, 3'h1, 2'h1, 2'h0, 3'h6},
      {14'h0781, 3'h2, 2'h2, 2'h0, 3'h6}, {14'h0082, 3'h0, 2'h2, 2'h0, 3'h6},
      {14'h0100, 3'h0, 2'h1, 2'h0, 3'h1}, {14'h0103, 3'h0, 2'h1, 2'h0, 3'h1},
      {14'h0016, 3'h2, 2'h2, 2'h2, 3'h7}, {14'h0016, 3'h1, 2'h1, 2'h2, 3'h7}};

   icd_decoder i_dut
   (
      .CLK_SYS(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwr), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy), .HRDATA(hrdata),
      .HREADYOUT(rdy), .HRESP(resp), .DEC_OUT(dec), .FILE_RD_STB(rd_s),
      .FILE_WR_STB(fw_s), .W_WR_STB(ww_s), .NOP_CYCLE(no_operation), .INSTR_DONE(done)
   );

   icd_datapath_model i_dp
   (
      .clk(clk), .srst(srst), .file_rd(rd_s), .file_wr(fw_s), .w_wr(ww_s), .done(done),
      .rd_cnt(n_rd), .fw_cnt(n_fw), .ww_cnt(n_ww), .done_cnt(n_dn)
   );

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Waits for a high sample of INSTR_DONE or of hready, with a bound.
   task automatic wait_high(input int lim, input bit on_done);
      cyc_n = 0;
      @(posedge clk);
      while ((on_done ? done : rdy) !== 1'b1)
      begin
         cyc_n++;
         if (cyc_n > lim)
         begin
            err_count++;
            finish_test();
         end
         @(posedge clk);
      end
   endtask

   // One single AHB-Lite transfer; read data lands in q.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwr <= w;
      haddr <= {24'h0, a};
      wait_high(40, 1'b0);
      htrans <= 2'h0;
      hwdata <= d;
      wait_high(40, 1'b0);
      q = hrdata;
      check("hresp", {31'h0, resp}, 32'h0);
   endtask

   task automatic run(input logic [23:0] e);
      logic [7:0] b_rd, b_fw, b_ww;
      bus(1'b1, icd_pkg::ICD_OFS_CTRL, {29'h0, e[9:7]});
      b_rd = n_rd;
      b_fw = n_fw;
      b_ww = n_ww;
      bus(1'b1, icd_pkg::ICD_OFS_INSTR, {18'h0, e[23:10]});
      wait_high(30, 1'b1);
      check("cycles", {30'h0, dec.cycles}, {30'h0, e[6:5]});
      check("time", 32'((cyc_n + 1) >> 2), {30'h0, e[6:5]});
      check("class", {30'h0, dec.cls}, {30'h0, e[4:3]});
      check("literal", {21'h0, dec.lit}, {21'h0, e[20:10]});
      if (e[2:0] != 3'h7)
      begin
         check("fadr", {25'h0, dec.fadr}, {25'h0, e[16:10]});
         if (e[4:3] == 2'h0)
            check("dest", {31'h0, dec.dest}, {31'h0, e[17]});
         else
            check("bitn", {29'h0, dec.bitn}, {29'h0, e[19:17]});
      end
      @(posedge clk);
      if (e[2:0] != 3'h7)
      begin
         check("reads", {24'h0, 8'(n_rd - b_rd)}, {31'h0, e[2]});
         check("file stores", {24'h0, 8'(n_fw - b_fw)}, {31'h0, e[1]});
         check("work stores", {24'h0, 8'(n_ww - b_ww)}, {31'h0, e[0]});
      end
   endtask

   initial
   begin
      srst = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      hwr = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      err_count = 0;
      checked = 0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      bus(1'b0, icd_pkg::ICD_OFS_CTRL, 32'h0);
      check("ctrl", q, {29'h0, icd_pkg::ICD_CTRL_RESET});
      bus(1'b0, icd_pkg::ICD_OFS_DECODE, 32'h0);
      check("decode", q, icd_pkg::ICD_DEC_RESET);
      bus(1'b0, icd_pkg::ICD_OFS_STATUS, 32'h0);
      check("status", q, 32'h0);
      bus(1'b1, icd_pkg::ICD_OFS_CTRL, 32'hffffffff);
      bus(1'b0, icd_pkg::ICD_OFS_CTRL, 32'h0);
      check("ctrl", q, 32'h7);
      bus(1'b1, 8'h10, 32'hffffffff);
      bus(1'b0, 8'h10, 32'h0);
      check("unmapped", q, 32'h0);
      $display("test registers done");
      foreach (TBL[i])
         run(TBL[i]);
      check("mode", {30'h0, dec.mode}, 32'h2);
      check("pointer", {31'h0, dec.ptr}, 32'h1);
      bus(1'b0, icd_pkg::ICD_OFS_STATUS, 32'h0);
      check("count", {24'h0, q[15:8]}, 32'h18);
      $display("test table done");
      b_dn = n_dn;
      bus(1'b1, icd_pkg::ICD_OFS_INSTR, {18'h0, 14'h2d55});
      bus(1'b1, icd_pkg::ICD_OFS_INSTR, {18'h0, 14'h07a0});
      @(posedge clk);
      check("stall", {24'h0, 8'(n_dn - b_dn)}, 32'h1);
      wait_high(30, 1'b1);
      @(posedge clk);
      check("done", {24'h0, 8'(n_dn - b_dn)}, 32'h2);
      bus(1'b0, icd_pkg::ICD_OFS_INSTR, 32'h0);
      check("instr", q, {18'h0, 14'h07a0});
      bus(1'b0, icd_pkg::ICD_OFS_DECODE, 32'h0);
      check("decode fadr", {25'h0, q[29:23]}, 32'h20);
      $display("test stall done");
      finish_test();
   end
endmodule

bind icd_decoder icd_decoder_assertions i_chk
(
   .CLK_SYS, .SRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA,
   .HREADYOUT, .HRESP, .DEC_OUT, .FILE_RD_STB, .FILE_WR_STB, .W_WR_STB, .NOP_CYCLE,
   .INSTR_DONE
);

`default_nettype wire
